/* File: rtl/line_ctrl_pkg.sv */
// package for the usb line conditioning control block
// assumes a 32-bit apb master on mclk
package line_ctrl_pkg;
  localparam logic [11:0] line_ctrl_offset = 12'h000;
  localparam logic [31:0] line_ctrl_reset  = 32'h0000_0000;
  localparam logic [7:0]  ctrl_reset       = 8'h00;
  localparam int          bit_dp_pullup    = 7;
  localparam int          bit_dm_pullup    = 6;
  localparam int          bit_dp_pulldown  = 5;
  localparam int          bit_dm_pulldown  = 4;
  localparam int          bit_power_drive  = 3;
  localparam int          bit_sw_select    = 2;
  localparam int          bit_charge       = 1;
  localparam int          bit_discharge    = 0;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;

  // four data-line resistor enables, same order as bits 7..4
  typedef struct packed {
    logic dplus_pullup_enable;
    logic dminus_pullup_enable;
    logic dplus_pulldown_enable;
    logic dminus_pulldown_enable;
  } line_res_type;
endpackage

/* File: rtl/usb_otg_line_control.sv */
// usb line conditioning control register with apb slave
// assumes usb core resistor requests are synchronous to mclk
// Behaviour
// [RQ1] bits 31..8 read zero and ignore writes
// [RQ2] bit 7 drives the d+ pull-up enable
// [RQ3] bit 6 drives the d- pull-up enable
// [RQ4] bit 5 drives the d+ pull-down enable
// [RQ5] bit 4 drives the d- pull-down enable
// [RQ6] bit 3 drives the vbus power output
// [RQ7] select bit 2 high: resistor enables follow register bits
// [RQ8] select bit low: resistor enables follow usb hardware
// [RQ9] bit 1 drives the vbus charge enable
// [RQ10] bit 0 drives the vbus discharge enable
// [RQ11] reset clears all eight control bits
module usb_otg_line_control
  import line_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       sys_rst,
  // apb
  input  wire line_ctrl_pkg::apb_req_type apb_req,
  output line_ctrl_pkg::apb_rsp_type      apb_rsp,
  // usb core requests
  input  wire line_ctrl_pkg::line_res_type hw_res,
  // line outputs
  output line_ctrl_pkg::line_res_type     line_res,
  output logic                            bus_power_drive,
  output logic                            bus_power_charge_enable,
  output logic                            bus_power_discharge_enable
);
  import line_ctrl_pkg::*;

  logic [7:0]   ctrl_reg;
  logic [7:0]   ctrl_next;
  apb_rsp_type  rsp_reg;
  apb_rsp_type  rsp_next;
  line_res_type res_reg;
  line_res_type res_next;
  logic [2:0]   pwr_reg;
  logic [2:0]   pwr_next;
  logic         hit;
  logic         access;
  logic         write_fire;

  function automatic logic addr_hit(input logic [11:0] a);
    return a == line_ctrl_offset;
  endfunction

  assign access = apb_req.psel && apb_req.penable;
  assign hit    = addr_hit(apb_req.paddr);
  // a write lands only in the access cycle that the registered pready closes
  assign write_fire = access && rsp_reg.pready && hit && apb_req.pwrite;

  // register and bus answer; zero-wait, so pready is set on the access cycle
  always_comb begin
    ctrl_next        = ctrl_reg;
    rsp_next.pready  = 1'b0;
    rsp_next.pslverr = 1'b0;
    rsp_next.prdata  = 32'h0000_0000;
    if (apb_req.psel && !apb_req.penable) begin
      // answer registered in setup so it is ready during access
      rsp_next.pready  = 1'b1;
      rsp_next.pslverr = !hit;
      if (hit && !apb_req.pwrite)
        rsp_next.prdata = {24'h00_0000, ctrl_reg}; // see [RQ1]
    end
    if (write_fire)
      ctrl_next = apb_req.pwdata[7:0]; // see [RQ1]
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= ctrl_reset; // see [RQ11]
      rsp_reg  <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      rsp_reg  <= rsp_next;
    end
  end

  // line drive; registered so outputs come from flip-flops, one cycle behind the register
  always_comb begin
    if (ctrl_reg[bit_sw_select]) begin // see [RQ7]
      res_next.dplus_pullup_enable    = ctrl_reg[bit_dp_pullup];   // see [RQ2]
      res_next.dminus_pullup_enable   = ctrl_reg[bit_dm_pullup];   // see [RQ3]
      res_next.dplus_pulldown_enable  = ctrl_reg[bit_dp_pulldown]; // see [RQ4]
      res_next.dminus_pulldown_enable = ctrl_reg[bit_dm_pulldown]; // see [RQ5]
    end else begin
      res_next = hw_res; // see [RQ8]
    end
    pwr_next = {ctrl_reg[bit_power_drive],  // see [RQ6]
                ctrl_reg[bit_charge],       // see [RQ9]
                ctrl_reg[bit_discharge]};   // see [RQ10]
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      res_reg <= '0;
      pwr_reg <= 3'h0;
    end else begin
      res_reg <= res_next;
      pwr_reg <= pwr_next;
    end
  end

  assign apb_rsp                    = rsp_reg;
  assign line_res                   = res_reg;
  assign bus_power_drive            = pwr_reg[2];
  assign bus_power_charge_enable    = pwr_reg[1];
  assign bus_power_discharge_enable = pwr_reg[0];

  sequence write_taken;
    access && apb_rsp.pready && apb_req.pwrite && hit;
  endsequence

  sequence setup_seen;
    apb_req.psel && !apb_req.penable;
  endsequence

  sequence read_taken;
    access && apb_rsp.pready && !apb_req.pwrite && hit;
  endsequence

  sequence miss_taken;
    access && apb_rsp.pready && !hit;
  endsequence

  sequence sw_write_taken;
    write_fire && apb_req.pwdata[bit_sw_select];
  endsequence

  sequence hw_write_taken;
    write_fire && !apb_req.pwdata[bit_sw_select];
  endsequence

  // two sampled edges in reset, so the async clear has settled
  sequence reset_held;
    sys_rst ##1 sys_rst;
  endsequence

  upper_zero_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ1]
    apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  dp_up_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ2]
    ctrl_reg[bit_sw_select] |=> line_res.dplus_pullup_enable == $past(ctrl_reg[bit_dp_pullup]))
    else $error("d+ pull-up not following register");
  dm_up_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ3]
    ctrl_reg[bit_sw_select] |=> line_res.dminus_pullup_enable == $past(ctrl_reg[bit_dm_pullup]))
    else $error("d- pull-up not following register");
  dp_down_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ4]
    ctrl_reg[bit_sw_select] |=> line_res.dplus_pulldown_enable == $past(ctrl_reg[bit_dp_pulldown]))
    else $error("d+ pull-down not following register");
  dm_down_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ5]
    ctrl_reg[bit_sw_select] |=> line_res.dminus_pulldown_enable == $past(ctrl_reg[bit_dm_pulldown]))
    else $error("d- pull-down not following register");
  power_write_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ6]
    write_taken |=> ##1 bus_power_drive == $past(apb_req.pwdata[bit_power_drive], 2))
    else $error("vbus power not following write");
  sw_select_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ7]
    sw_write_taken |=> ##1 line_res[3] == $past(apb_req.pwdata[bit_dp_pullup], 2))
    else $error("software select ignored");
  hw_select_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ8]
    !ctrl_reg[bit_sw_select] |=> line_res == $past(hw_res))
    else $error("hardware control not followed");
  charge_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ9]
    write_taken |=> ##1 bus_power_charge_enable == $past(apb_req.pwdata[bit_charge], 2))
    else $error("charge enable not following write");
  discharge_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ10]
    write_taken |=> ##1 bus_power_discharge_enable == $past(apb_req.pwdata[bit_discharge], 2))
    else $error("discharge enable not following write");
  reset_clear_a: assert property (@(posedge mclk) // see [RQ11]
    $fell(sys_rst) |-> ctrl_reg == 8'h00 && pwr_reg == 3'h0)
    else $error("control not cleared by reset");

  // bus answer
  ready_after_setup_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ1]
    setup_seen |=> apb_rsp.pready)
    else $error("no ready after setup");

  access_ready_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ1]
    setup_seen ##1 access |-> apb_rsp.pready)
    else $error("access cycle without ready");

  idle_no_ready_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ1]
    !apb_req.psel |=> !apb_rsp.pready)
    else $error("ready without a setup");

  ready_single_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ1]
    apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready stands more than one cycle");

  error_ready_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ1]
    apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("error without ready");

  data_ready_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ1]
    apb_rsp.prdata != 32'h0000_0000 |-> apb_rsp.pready)
    else $error("read data outside the access cycle");

  read_data_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ1]
    read_taken |-> apb_rsp.prdata == {24'h00_0000, ctrl_reg})
    else $error("read data differs from control");

  read_ok_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ1]
    read_taken |-> !apb_rsp.pslverr)
    else $error("error on mapped read");

  write_ok_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ1]
    write_taken |-> !apb_rsp.pslverr)
    else $error("error on mapped write");

  write_zero_data_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ1]
    write_taken |-> apb_rsp.prdata == 32'h0000_0000)
    else $error("read data driven on write");

  miss_error_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ1]
    miss_taken |-> apb_rsp.pslverr)
    else $error("no error on unmapped address");

  miss_zero_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ1]
    miss_taken |-> apb_rsp.prdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // control register
  write_lands_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ1]
    write_taken |=> ctrl_reg == $past(apb_req.pwdata[7:0]))
    else $error("write did not land");

  miss_keeps_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ1]
    miss_taken |=> $stable(ctrl_reg))
    else $error("unmapped write changed control");

  hold_ctrl_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ1]
    !write_fire |=> $stable(ctrl_reg))
    else $error("control changed without a write");

  read_keeps_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ1]
    read_taken |=> $stable(ctrl_reg))
    else $error("read changed control");

  // line and vbus outputs
  sw_group_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ7]
    ctrl_reg[bit_sw_select] |=> line_res == $past(ctrl_reg[7:4]))
    else $error("resistor group not from register");

  sw_select_on_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ7]
    sw_write_taken |=> ##1 line_res == $past(apb_req.pwdata[7:4], 2))
    else $error("software group not applied");

  hw_write_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ8]
    hw_write_taken |=> !ctrl_reg[bit_sw_select])
    else $error("hardware select not stored");

  hw_dp_up_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ8]
    !ctrl_reg[bit_sw_select] |=>
      line_res.dplus_pullup_enable == $past(hw_res.dplus_pullup_enable))
    else $error("d+ pull-up not from hardware");

  hw_dm_up_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ8]
    !ctrl_reg[bit_sw_select] |=>
      line_res.dminus_pullup_enable == $past(hw_res.dminus_pullup_enable))
    else $error("d- pull-up not from hardware");

  hw_dp_down_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ8]
    !ctrl_reg[bit_sw_select] |=>
      line_res.dplus_pulldown_enable == $past(hw_res.dplus_pulldown_enable))
    else $error("d+ pull-down not from hardware");

  hw_dm_down_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ8]
    !ctrl_reg[bit_sw_select] |=>
      line_res.dminus_pulldown_enable == $past(hw_res.dminus_pulldown_enable))
    else $error("d- pull-down not from hardware");

  power_follow_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ6]
    1'b1 |=> bus_power_drive == $past(ctrl_reg[bit_power_drive]))
    else $error("vbus power not following control");

  power_off_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ6]
    !ctrl_reg[bit_power_drive] |=> !bus_power_drive)
    else $error("vbus powered with bit clear");

  charge_follow_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ9]
    1'b1 |=> bus_power_charge_enable == $past(ctrl_reg[bit_charge]))
    else $error("charge enable not following control");

  discharge_follow_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ10]
    1'b1 |=> bus_power_discharge_enable == $past(ctrl_reg[bit_discharge]))
    else $error("discharge enable not following control");

  // reset
  reset_lines_a: assert property (@(posedge mclk) // see [RQ11]
    reset_held |-> line_res == 4'h0 && !bus_power_drive &&
      !bus_power_charge_enable && !bus_power_discharge_enable)
    else $error("outputs active in reset");

  reset_bus_a: assert property (@(posedge mclk) // see [RQ11]
    reset_held |-> !apb_rsp.pready && !apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000)
    else $error("bus answer active in reset");

  reset_ctrl_a: assert property (@(posedge mclk) // see [RQ11]
    reset_held |-> ctrl_reg == ctrl_reset)
    else $error("control not at reset value");

  release_select_a: assert property (@(posedge mclk) // see [RQ11]
    $fell(sys_rst) |-> !ctrl_reg[bit_sw_select])
    else $error("software select set after reset");

  release_bus_a: assert property (@(posedge mclk) // see [RQ11]
    $fell(sys_rst) |-> !apb_rsp.pready)
    else $error("ready right after reset");

  release_hw_a: assert property (@(posedge mclk) disable iff (sys_rst) // see [RQ11]
    $fell(sys_rst) |=> line_res == $past(hw_res))
    else $error("lines not under hardware after reset");
endmodule

/* File: tb/usb_line_partner.sv */
// far-side model: the usb core that asks for line resistors
// assumes its requests are registered on mclk, as the block expects
module usb_line_partner (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  // request pattern chosen by the bench
  input  wire logic [3:0]             pattern,
  // requests toward the block
  output line_ctrl_pkg::line_res_type hw_res
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) hw_res <= '0;
    else hw_res <= pattern;
  end
endmodule

/* File: tb/test_usb_otg_line_control.sv */
// bench for the line conditioning control block
// assumes a zero-wait apb answer and outputs one clock behind the register
module test_usb_otg_line_control;
  timeunit 1ns;
  timeprecision 1ps;
  import line_ctrl_pkg::*;
  logic         mclk = 1'b0;
  logic         sys_rst = 1'b1;
  apb_req_type  apb_req = '0;
  apb_rsp_type  apb_rsp;
  line_res_type line_res, hw_res;
  logic         drive, charge, discharge, err;
  logic [3:0]   pattern = 4'h0;
  logic [31:0]  rd;
  logic [7:0]   w;
  int           n_mismatch = 0;
  int           tests_run = 0;
  always #5 mclk = ~mclk;
  usb_otg_line_control usb_otg_line_control_inst (.mclk(mclk), .sys_rst(sys_rst),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .hw_res(hw_res), .line_res(line_res),
    .bus_power_drive(drive), .bus_power_charge_enable(charge),
    .bus_power_discharge_enable(discharge));
  usb_line_partner usb_line_partner_inst (.mclk(mclk), .sys_rst(sys_rst),
    .pattern(pattern), .hw_res(hw_res));
  task conclude;
    if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one idle cycle between transfers keeps each signal to one update per step
  task apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    int n;
    @(posedge mclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: data};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 16);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    if (apb_rsp.pready !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
  endtask
  task outputs(input logic [7:0] v, input logic [3:0] h);
    check({25'h0, line_res, drive, charge, discharge},
          {25'h0, v[2] ? v[7:4] : h, v[3], v[1], v[0]});
  endtask
  // upper bits carry junk so that a leak into the register shows on read-back
  task step(input logic [7:0] v, input logic [3:0] h);
    @(posedge mclk);
    pattern <= h;
    apb(1'b1, line_ctrl_offset, {24'ha5a5a5, v});
    check({31'h0, err}, 32'h0);
    apb(1'b0, line_ctrl_offset, 32'h0);
    check(rd, {24'h0, v});
    repeat (3) @(posedge mclk);
    #1 outputs(v, h);
  endtask
  initial begin
    #300000 n_mismatch++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge mclk);
    #1 outputs(8'h00, 4'h0);
    @(posedge mclk);
    sys_rst <= 1'b0;
    apb(1'b0, line_ctrl_offset, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      w = 8'h04 | (8'h01 << i);
      step(w, ~w[7:4]);
    end
    step(8'hf0, 4'h5);
    step(8'hff, 4'h0);
    apb(1'b1, 12'h004, 32'h0000_0000);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, line_ctrl_offset, 32'h0);
    check(rd, 32'h0000_00ff);
    step(8'h00, 4'h9);
    step(8'h2e, 4'h3);
    @(posedge mclk);
    sys_rst <= 1'b1;
    @(posedge mclk);
    #1 outputs(8'h00, 4'h0);
    @(posedge mclk);
    sys_rst <= 1'b0;
    apb(1'b0, line_ctrl_offset, 32'h0);
    check(rd, 32'h0);
    conclude();
  end
endmodule
